// *** include/crcc_defs.svh ***
// Register map, field positions, polynomials and sizes of the CRC calculator
`ifndef CRCC_DEFS_SVH
`define CRCC_DEFS_SVH

`define CRCC_ADDR_W           12
`define CRCC_OFF_CONTROL      12'h000
`define CRCC_OFF_DATA_IN      12'h004
`define CRCC_OFF_DATA_OUT     12'h008
`define CRCC_OFF_ENGINE       12'h00C

`define CRCC_POLY_SEL_LSB     0
`define CRCC_POLY_SEL_MSB     2
`define CRCC_BIT_ORDER_BIT    6
`define CRCC_CONTROL_MASK     8'h47
`define CRCC_CONTROL_RESET    8'h00
`define CRCC_DATA_IN_RESET    32'h00000000
`define CRCC_DATA_OUT_RESET   32'h00000000
`define CRCC_ENG_HOLD_BIT     0
`define CRCC_ENG_COUNT_LSB    4

`define CRCC_SEL_P8           3'h1
`define CRCC_SEL_P16A         3'h2
`define CRCC_SEL_P16B         3'h3
`define CRCC_SEL_P32A         3'h4
`define CRCC_SEL_P32B         3'h5

`define CRCC_POLY_P8          32'h00000007
`define CRCC_REFL_P8          32'h000000E0
`define CRCC_POLY_P16A        32'h00008005
`define CRCC_REFL_P16A        32'h0000A001
`define CRCC_POLY_P16B        32'h00001021
`define CRCC_REFL_P16B        32'h00008408
`define CRCC_POLY_P32A        32'h04C11DB7
`define CRCC_REFL_P32A        32'hEDB88320
`define CRCC_POLY_P32B        32'h1EDC6F41
`define CRCC_REFL_P32B        32'h82F63B78

`define CRCC_MASK_W8          32'h000000FF
`define CRCC_MASK_W16         32'h0000FFFF
`define CRCC_MASK_W32         32'hFFFFFFFF

`define CRCC_STRB_BYTE        4'h1
`define CRCC_STRB_WORD        4'hF
`define CRCC_FIFO_WIDTH       32
`define CRCC_FIFO_DEPTH       4
`define CRCC_FIFO_CNT_W       3
`define CRCC_FIFO_FULL_COUNT  3'h4
`define CRCC_FIFO_EMPTY_COUNT 3'h0

`endif

// *** include/crcc_pkg.sv ***
// Types shared by the CRC calculator modules
package crcc_pkg;

    typedef enum logic [1:0] {
        width_none,
        width_8,
        width_16,
        width_32
    } crcc_width_t;

endpackage

// *** design/crcc_fifo.sv ***
// Word FIFO between the register bus and the CRC folding engine
`timescale 1ns/1ps
module crcc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Filling side
    input  wire logic                         in_valid,
    output logic                              in_ready,
    input  wire logic [WIDTH-1:0]             in_data,
    // Draining side
    output logic                              out_valid,
    input  wire logic                         out_ready,
    output logic [WIDTH-1:0]                  out_data,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0]        count
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready  = (count != CNT_W'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers wrap naturally only for a power-of-two depth
    for (genvar e = 0; e < DEPTH; e++) begin : g_entry
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem[e] <= '0;
            end else if (push && wr_ptr == PTR_W'(e)) begin
                mem[e] <= in_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

endmodule

// *** design/crcc_top.sv ***
// APB CRC calculator: control, data input, checksum output, input FIFO
//
// How it works
// R1: select codes 000, 110, 111 compute nothing
// R2: codes 001-011 pick 8-bit and 16-bit polynomials
// R3: codes 100 and 101 pick 32-bit polynomials
// R4: 8/16-bit modes fold one byte per write
// R5: 32-bit modes fold one full word per write
// R6: control bit 6 picks LSB-first or MSB-first
// R7: software writes input as word or byte accordingly
// R8: checksum read width follows selected CRC size
// R9: input writes update remainder; output register seedable
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "crcc_defs.svh"
module crcc_top (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB request
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`CRCC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    // APB answer
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr
);

    logic [7:0]                  crc_control;
    logic [31:0]                 crc_data_in;
    logic [31:0]                 crc_data_out;
    logic                        hold;
    logic [2:0]                  poly_select;
    logic                        bit_order_select;
    crcc_pkg::crcc_width_t       width;
    logic [31:0]                 poly_norm;
    logic [31:0]                 poly_refl;
    logic [31:0]                 width_mask;
    logic                        access;
    logic                        done;
    logic                        sel_ctrl;
    logic                        sel_din;
    logic                        sel_dout;
    logic                        sel_eng;
    logic                        mapped;
    logic                        size_ok;
    logic                        push_ok;
    logic                        quiet;
    logic                        can_go;
    logic                        err;
    logic [31:0]                 read_value;
    logic                        fifo_in_valid;
    logic                        fifo_in_ready;
    logic                        fifo_out_valid;
    logic                        fifo_out_ready;
    logic [31:0]                 fifo_out_data;
    logic [`CRCC_FIFO_CNT_W-1:0] fifo_count;
    logic                        pop;
    logic                        dout_write;
    logic [31:0]                 next_data_out;

    assign poly_select      = crc_control[`CRCC_POLY_SEL_MSB:`CRCC_POLY_SEL_LSB];
    assign bit_order_select = crc_control[`CRCC_BIT_ORDER_BIT];

    // Polynomial decode; unlisted codes fall to no calculation
    always_comb begin
        width     = crcc_pkg::width_none;
        poly_norm = 32'h00000000;
        poly_refl = 32'h00000000;
        case (poly_select)
            `CRCC_SEL_P8: begin // see R2
                width     = crcc_pkg::width_8;
                poly_norm = `CRCC_POLY_P8;
                poly_refl = `CRCC_REFL_P8;
            end
            `CRCC_SEL_P16A: begin // see R2
                width     = crcc_pkg::width_16;
                poly_norm = `CRCC_POLY_P16A;
                poly_refl = `CRCC_REFL_P16A;
            end
            `CRCC_SEL_P16B: begin // see R2
                width     = crcc_pkg::width_16;
                poly_norm = `CRCC_POLY_P16B;
                poly_refl = `CRCC_REFL_P16B;
            end
            `CRCC_SEL_P32A: begin // see R3
                width     = crcc_pkg::width_32;
                poly_norm = `CRCC_POLY_P32A;
                poly_refl = `CRCC_REFL_P32A;
            end
            `CRCC_SEL_P32B: begin // see R3
                width     = crcc_pkg::width_32;
                poly_norm = `CRCC_POLY_P32B;
                poly_refl = `CRCC_REFL_P32B;
            end
            default: begin // see R1
                width = crcc_pkg::width_none;
            end
        endcase
    end

    always_comb begin
        case (width)
            crcc_pkg::width_8:  width_mask = `CRCC_MASK_W8;
            crcc_pkg::width_16: width_mask = `CRCC_MASK_W16;
            default:            width_mask = `CRCC_MASK_W32;
        endcase
    end

    // Bit-serial model unrolled into one combinational step
    function automatic logic [31:0] crcc_fold(
        input logic [31:0]           rem,
        input logic [31:0]           data,
        input crcc_pkg::crcc_width_t w,
        input logic [31:0]           pn,
        input logic [31:0]           pr,
        input logic                  msb_first
    );
        logic [31:0] r;
        logic [31:0] mask;
        int          nbits;
        int          top;
        logic        fb;
        case (w)
            crcc_pkg::width_8: begin
                nbits = 8;
                top   = 7;
                mask  = `CRCC_MASK_W8;
            end
            crcc_pkg::width_16: begin
                nbits = 8;
                top   = 15;
                mask  = `CRCC_MASK_W16;
            end
            default: begin
                nbits = 32;
                top   = 31;
                mask  = `CRCC_MASK_W32;
            end
        endcase
        r  = rem & mask;
        fb = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (i < nbits) begin
                if (msb_first) begin // see R6
                    fb = r[top] ^ data[nbits-1-i];
                    r  = ((r << 1) & mask) ^ (fb ? pn : 32'h00000000);
                end else begin
                    fb = r[0] ^ data[i];
                    r  = (r >> 1) ^ (fb ? pr : 32'h00000000);
                end
            end
        end
        return r;
    endfunction

    // APB decode
    assign access   = psel & penable;
    assign done     = access & pready;
    assign sel_ctrl = (paddr == `CRCC_OFF_CONTROL);
    assign sel_din  = (paddr == `CRCC_OFF_DATA_IN);
    assign sel_dout = (paddr == `CRCC_OFF_DATA_OUT);
    assign sel_eng  = (paddr == `CRCC_OFF_ENGINE);
    assign mapped   = sel_ctrl | sel_din | sel_dout | sel_eng;

    // Wrong access size is refused so a stray word never folds as a byte
    assign size_ok = (width == crcc_pkg::width_32) ?
                     (pstrb == `CRCC_STRB_WORD) :
                     (pstrb == `CRCC_STRB_BYTE); // see R7
    assign push_ok = sel_din & pwrite & size_ok &
                     (width != crcc_pkg::width_none); // see R1
    assign err     = !mapped |
                     (sel_din & pwrite & !size_ok &
                      (width != crcc_pkg::width_none));

    // Control and checksum wait for queued words, unless software holds
    assign quiet  = hold | (fifo_count == `CRCC_FIFO_EMPTY_COUNT);
    assign can_go = !mapped | sel_eng | (sel_din & !pwrite) |
                    (sel_din & pwrite & (!push_ok | fifo_in_ready)) |
                    ((sel_ctrl | sel_dout) & quiet);

    always_comb begin
        read_value = 32'h00000000;
        if (sel_ctrl) begin
            read_value[7:0] = crc_control;
        end else if (sel_din) begin
            read_value = crc_data_in;
        end else if (sel_dout) begin
            read_value = crc_data_out & width_mask; // see R8
        end else if (sel_eng) begin
            read_value[`CRCC_ENG_HOLD_BIT] = hold;
            read_value[`CRCC_ENG_COUNT_LSB +: `CRCC_FIFO_CNT_W] = fifo_count;
        end
    end

    // One wait state at least; the answer stands for a single cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (done) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (access && can_go) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h00000000 : read_value;
            pslverr <= err;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_control <= `CRCC_CONTROL_RESET;
        end else if (done && pwrite && sel_ctrl && pstrb[0]) begin
            crc_control <= pwdata[7:0] & `CRCC_CONTROL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= 1'b0;
        end else if (done && pwrite && sel_eng && pstrb[0]) begin
            hold <= pwdata[`CRCC_ENG_HOLD_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_data_in <= `CRCC_DATA_IN_RESET;
        end else if (done && pwrite && sel_din && !err) begin
            crc_data_in <= pwdata;
        end
    end

    assign fifo_in_valid  = done & push_ok;
    assign dout_write     = done & pwrite & sel_dout;
    assign fifo_out_ready = !hold & !dout_write;
    assign pop            = fifo_out_valid & fifo_out_ready;

    crcc_fifo #(
        .WIDTH (`CRCC_FIFO_WIDTH),
        .DEPTH (`CRCC_FIFO_DEPTH)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (pwdata),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .count     (fifo_count)
    );

    always_comb begin
        next_data_out = crc_data_out;
        for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
                next_data_out[8*b +: 8] = pwdata[8*b +: 8];
            end
        end
    end

    // Seeding wins over folding; folding is held off in that cycle anyway
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_data_out <= `CRCC_DATA_OUT_RESET;
        end else if (dout_write) begin
            crc_data_out <= next_data_out; // see R9
        end else if (pop && width != crcc_pkg::width_none) begin // see R1
            crc_data_out <= crcc_fold(crc_data_out, fifo_out_data, width,
                                      poly_norm, poly_refl,
                                      bit_order_select); // see R4, R5, R9
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_none_still: assert property ( // see R1
        (access && pwrite && sel_din && width == crcc_pkg::width_none)
        |-> !fifo_in_valid ##1 (!fifo_in_valid && $stable(crc_data_out)))
        else $error("no-calculation mode queued a data word");

    a_crc8_msb: assert property ( // see R2
        (pop && poly_select == `CRCC_SEL_P8 && bit_order_select &&
         (crc_data_out & `CRCC_MASK_W8) == 32'h00000000 &&
         fifo_out_data[7:0] == 8'h01)
        |=> crc_data_out[7:0] == 8'h07)
        else $error("8-bit fold of 01 does not give the polynomial");

    a_crc16_lsb: assert property ( // see R2, R6
        (pop && poly_select == `CRCC_SEL_P16B && !bit_order_select &&
         (crc_data_out & `CRCC_MASK_W16) == 32'h00000000 &&
         fifo_out_data[7:0] == 8'h80)
        |=> crc_data_out[15:0] == 16'h8408)
        else $error("16-bit reflected fold of 80 is wrong");

    a_crc32_msb: assert property ( // see R3, R5
        (pop && poly_select == `CRCC_SEL_P32B && bit_order_select &&
         crc_data_out == 32'h00000000 && fifo_out_data == 32'h00000001)
        |=> crc_data_out == 32'h1EDC6F41)
        else $error("32-bit fold of one does not give the polynomial");

    a_crc32_lsb: assert property ( // see R3, R6
        (pop && poly_select == `CRCC_SEL_P32A && !bit_order_select &&
         crc_data_out == 32'h00000000 && fifo_out_data == 32'h80000000)
        |=> crc_data_out == 32'hEDB88320)
        else $error("32-bit reflected fold of top bit is wrong");

    a_byte_only: assert property ( // see R4
        (pop && (width == crcc_pkg::width_8 || width == crcc_pkg::width_16)
         && (crc_data_out & width_mask) == 32'h00000000 &&
         fifo_out_data[7:0] == 8'h00)
        |=> (crc_data_out & width_mask) == 32'h00000000)
        else $error("upper data bits leaked into a byte fold");

    a_size_refused: assert property ( // see R7
        (done && pwrite && sel_din && !size_ok &&
         width != crcc_pkg::width_none)
        |-> pslverr && !fifo_in_valid)
        else $error("wrong-size data write was not refused");

    a_read_width: assert property ( // see R8
        (access && !pready && can_go && !pwrite && sel_dout &&
         width == crcc_pkg::width_8)
        |=> pready && prdata[31:8] == 24'h000000)
        else $error("8-bit checksum read shows upper bits");

    a_seed_write: assert property ( // see R9
        (done && pwrite && sel_dout && pstrb == `CRCC_STRB_WORD)
        |=> crc_data_out == $past(pwdata))
        else $error("checksum seed did not land");

    a_fold_follows: assert property ( // see R9
        (fifo_in_valid && !hold && fifo_count == `CRCC_FIFO_EMPTY_COUNT)
        |=> pop ##1 (fifo_count == `CRCC_FIFO_EMPTY_COUNT))
        else $error("queued word was not folded next cycle");

    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("pready stood longer than one cycle");

    a_full_stall: assert property (
        (access && !pready && push_ok && !fifo_in_ready)
        |=> !pready)
        else $error("write answered while the FIFO was full");

    c_fifo_full: cover property (fifo_count == `CRCC_FIFO_FULL_COUNT);
    c_crc32_pop: cover property (pop && width == crcc_pkg::width_32);
    c_seed_fold: cover property (dout_write ##[1:20] pop);
    c_slverr:    cover property (done && pslverr);

endmodule

// *** tb/crc_calculator_8_32_bench.sv ***
// Self-checking bench for the APB CRC calculator
`timescale 1ns/1ps
`include "crcc_defs.svh"
module crc_calculator_8_32_bench;
    typedef struct packed {
        logic        rd;
        logic [31:0] d;
        logic        e;
    } crcc_note_t;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    crcc_note_t  notes[$];
    crcc_note_t  nt;
    int          fails;
    int          comparisons;
    integer      seed;
    logic [31:0] rem;
    logic [31:0] dat;
    logic [31:0] msk;
    logic [3:0]  sz;
    int          w;

    crcc_top i_crcc_top (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // One APB transfer; the expected answer is queued for the watcher
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       input logic [31:0] exp, input logic err);
        int n;
        notes.push_back('{rd: ~wr, d: exp, e: err});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 2000);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 2000) begin
            fails++;
            complete_run();
        end
    endtask

    function automatic int wid(input logic [2:0] c);
        case (c)
            3'h1: return 8;
            3'h2, 3'h3: return 16;
            3'h4, 3'h5: return 32;
            default: return 0;
        endcase
    endfunction

    // Bit-serial reference fold, one data bit per step
    function automatic logic [31:0] fold(input logic [31:0] r,
            input logic [31:0] d, input logic [2:0] c, input logic m);
        int          wd;
        int          n;
        logic [31:0] p;
        logic [31:0] q;
        logic [31:0] k;
        logic        fb;
        wd = wid(c);
        n = (wd == 32) ? 32 : 8;
        k = (wd == 32) ? 32'hFFFFFFFF : ((32'h1 << wd) - 32'h1);
        case (c)
            3'h1: begin p = `CRCC_POLY_P8;   q = `CRCC_REFL_P8;   end
            3'h2: begin p = `CRCC_POLY_P16A; q = `CRCC_REFL_P16A; end
            3'h3: begin p = `CRCC_POLY_P16B; q = `CRCC_REFL_P16B; end
            3'h4: begin p = `CRCC_POLY_P32A; q = `CRCC_REFL_P32A; end
            3'h5: begin p = `CRCC_POLY_P32B; q = `CRCC_REFL_P32B; end
            default: return r;
        endcase
        for (int i = 0; i < n; i++) begin
            if (m) begin
                fb = r[wd-1] ^ d[n-1-i];
                r = (r << 1) & k;
            end else begin
                fb = r[0] ^ d[i];
                r = r >> 1;
            end
            if (fb) r = r ^ (m ? p : q);
        end
        return r;
    endfunction

    // Watcher: every answered transfer consumes the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                nt = notes.pop_front();
                check({31'h0, pslverr}, {31'h0, nt.e});
                if (nt.rd) check(prdata, nt.d);
            end
        end
    end

    initial begin
        seed = 70;
        fails = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then the mapped field mask and an unmapped place
        apb(1'b0, 12'h000, 32'h0, 4'h0, 32'h00000000, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 4'h0, 32'h00000000, 1'b0);
        apb(1'b0, 12'h008, 32'h0, 4'h0, 32'h00000000, 1'b0);
        apb(1'b1, 12'h000, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b0);
        apb(1'b0, 12'h000, 32'h0, 4'h0, 32'h00000047, 1'b0);
        apb(1'b1, 12'h010, 32'h12345678, 4'hF, 32'h0, 1'b1);
        apb(1'b0, 12'h010, 32'h0, 4'h0, 32'h00000000, 1'b1);
        // Every select code in both bit orders
        for (int c = 0; c < 8; c++) begin
            for (int m = 0; m < 2; m++) begin
                w = wid(c[2:0]);
                msk = (w == 32 || w == 0) ? 32'hFFFFFFFF
                                          : ((32'h1 << w) - 32'h1);
                sz = (w == 32) ? `CRCC_STRB_WORD : `CRCC_STRB_BYTE;
                if (w == 0) sz = `CRCC_STRB_WORD;
                // Half the passes start from zero with a known first word
                rem = (m[0] == (c[0] & ~c[1])) ? 32'h0 : $random(seed) & msk;
                apb(1'b1, 12'h000, {25'h0, m[0], 3'h0, c[2:0]}, 4'hF,
                    32'h0, 1'b0);
                apb(1'b1, 12'h008, rem, 4'hF, 32'h0, 1'b0);
                for (int k = 0; k < 3; k++) begin
                    dat = $random(seed);
                    if (k == 0 && rem == 32'h0) begin
                        dat = m[0] ? 32'h1 : 32'h80;
                        if (w == 32 && !m[0]) dat = 32'h80000000;
                    end
                    if (sz == `CRCC_STRB_BYTE) dat = dat & 32'hFF;
                    apb(1'b1, 12'h004, dat, sz, 32'h0, 1'b0);
                    rem = fold(rem, dat, c[2:0], m[0]);
                end
                if (w == 32) begin
                    apb(1'b0, 12'h004, 32'h0, 4'h0, dat, 1'b0);
                end
                // Wrong access size is refused and folds nothing
                if (w != 0) begin
                    apb(1'b1, 12'h004, 32'hA5, (w == 32) ? 4'h1 : 4'hF,
                        32'h0, 1'b1);
                end
                apb(1'b0, 12'h008, 32'h0, 4'h0, rem & msk, 1'b0);
            end
        end
        // Buffer: hold the engine, fill four words, then let it drain
        apb(1'b1, 12'h000, 32'h00000044, 4'hF, 32'h0, 1'b0);
        apb(1'b1, 12'h008, 32'h0, 4'hF, 32'h0, 1'b0);
        apb(1'b1, 12'h00C, 32'h1, 4'hF, 32'h0, 1'b0);
        rem = 32'h0;
        for (int k = 0; k < 4; k++) begin
            dat = $random(seed);
            apb(1'b1, 12'h004, dat, 4'hF, 32'h0, 1'b0);
            rem = fold(rem, dat, 3'h4, 1'b1);
        end
        apb(1'b0, 12'h00C, 32'h0, 4'h0, 32'h00000041, 1'b0);
        apb(1'b1, 12'h00C, 32'h0, 4'hF, 32'h0, 1'b0);
        apb(1'b0, 12'h008, 32'h0, 4'h0, rem, 1'b0);
        apb(1'b0, 12'h00C, 32'h0, 4'h0, 32'h00000000, 1'b0);
        repeat (4) @(posedge pclk);
        check(notes.size(), 32'h0);
        complete_run();
    end
endmodule
